// file: shared/flow_ctrl_pkg.sv
`default_nettype none
package flow_ctrl_pkg;
   // flow mode field codes
   localparam logic [2:0] FLOW_NONE      = 3'h0;
   localparam logic [2:0] FLOW_HW        = 3'h1;
   localparam logic [2:0] FLOW_SW        = 3'h2;
   localparam logic [2:0] FLOW_MD_TXANY  = 3'h3;
   localparam logic [2:0] FLOW_MD_TXADDR = 3'h4;
   // pin function select codes
   localparam logic [2:0] PIN_GPIO       = 3'h0;
   localparam logic [2:0] PIN_RTS_CTS    = 3'h1;
   localparam logic [2:0] PIN_DTR_DSR    = 3'h2;
   localparam logic [2:0] PIN_RS485_A    = 3'h3;
   localparam logic [2:0] PIN_RS485_B    = 3'h4;
   // field positions
   localparam int         HALF_DUPLEX_BIT = 3;
   localparam int         DE_INVERT_BIT   = 3;
   // turn-around delay range, in bit times
   localparam logic [3:0] DELAY_MAX      = 4'hF;
   localparam logic [3:0] DELAY_ZERO     = 4'h0;
   // receive FIFO depth and threshold for space
   localparam int         RX_LEVEL_W     = 9;
   localparam logic [8:0] RX_FIFO_DEPTH  = 9'h180;
   // synchroniser width
   localparam int         SYNC_STAGES    = 3;
endpackage : flow_ctrl_pkg
`default_nettype wire

// file: rtl/pin_sync.sv
`default_nettype none
// ==========================================
// three-stage synchroniser with agreement filter
module pin_sync (
   input  wire logic ref_clk,
   input  wire logic rst_n,
   input  wire logic pin_in,
   output var  logic pin_out
);
   logic [flow_ctrl_pkg::SYNC_STAGES-1:0] sync_reg;

   // first stage is read only by the second
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         sync_reg <= 3'h7;
      end else begin
         sync_reg <= {sync_reg[1:0], pin_in};
      end
   end

   // accept a change only once stages two and three agree
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_out <= 1'b1;
      end else if (sync_reg[1] == sync_reg[2]) begin
         pin_out <= sync_reg[2];
      end
   end
endmodule : pin_sync
`default_nettype wire

// file: rtl/uart_flow_multidrop_control.sv
`default_nettype none
module uart_flow_multidrop_control (
   input  wire logic                               ref_clk,
   input  wire logic                               rst_n,
   // configuration
   input  wire logic [3:0]                         flow_mode,
   input  wire logic [3:0]                         pin_mode,
   input  wire logic [7:0]                         resume_char,
   input  wire logic [7:0]                         stop_char,
   input  wire logic [3:0]                         turnaround_delay,
   // transmit shift path
   input  wire logic                               tx_pending,
   input  wire logic                               tx_busy,
   input  wire logic                               tx_char_done,
   input  wire logic                               bit_tick,
   output var  logic                               tx_start_ok,
   // receive path
   input  wire logic                               rx_valid,
   input  wire logic [8:0]                         rx_data,
   input  wire logic [flow_ctrl_pkg::RX_LEVEL_W-1:0] rx_level,
   output var  logic                               rx_write,
   output var  logic [7:0]                         rx_write_data,
   // pins
   input  wire logic                               general_pin_4,
   input  wire logic                               general_pin_2,
   output var  logic                               general_pin_5,
   output var  logic                               general_pin_3,
   output var  logic                               md_rx_enabled,
   output var  logic                               sw_halted
);
   // ==========================================
   // mode decode
   typedef enum logic [2:0] {
      DE_IDLE  = 3'h1,
      DE_SEND  = 3'h2,
      DE_HOLD  = 3'h4
   } de_state_t;

   function automatic logic is_multidrop(input logic [2:0] m);
      is_multidrop = (m == flow_ctrl_pkg::FLOW_MD_TXANY) || (m == flow_ctrl_pkg::FLOW_MD_TXADDR);
   endfunction : is_multidrop

   wire logic [2:0] fmode      = flow_mode[2:0];
   wire logic [2:0] pmode      = pin_mode[2:0];
   wire logic       hw_flow    = (fmode == flow_ctrl_pkg::FLOW_HW);
   wire logic       sw_flow    = (fmode == flow_ctrl_pkg::FLOW_SW);
   wire logic       md_mode    = is_multidrop(fmode);
   wire logic       rts_mode   = hw_flow && (pmode == flow_ctrl_pkg::PIN_RTS_CTS);
   wire logic       dtr_mode   = hw_flow && (pmode == flow_ctrl_pkg::PIN_DTR_DSR);
   wire logic       rs485_mode = is_multidrop(pmode);
   wire logic       de_invert  = pin_mode[flow_ctrl_pkg::DE_INVERT_BIT];
   wire logic       half_dup   = flow_mode[flow_ctrl_pkg::HALF_DUPLEX_BIT];

   // ==========================================
   // synchronised handshake inputs
   logic cts_sync;
   logic dsr_sync;

   pin_sync cts_sync_inst (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .pin_in  (general_pin_4),
      .pin_out (cts_sync)
   );

   pin_sync dsr_sync_inst (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .pin_in  (general_pin_2),
      .pin_out (dsr_sync)
   );

   // ==========================================
   // receive classification
   wire logic rx_blank     = half_dup && tx_busy;
   wire logic rx_take      = rx_valid && !rx_blank;
   wire logic is_addr      = rx_data[8];
   wire logic addr_match   = (rx_data[7:0] == resume_char) || (rx_data[7:0] == stop_char);
   wire logic sw_stop_hit  = sw_flow && (rx_data[7:0] == stop_char);
   wire logic sw_go_hit    = sw_flow && (rx_data[7:0] == resume_char);
   wire logic md_addr_byte = md_mode && is_addr;
   wire logic store_ok     = md_mode ? (md_rx_enabled && !is_addr) : !(sw_stop_hit || sw_go_hit);
   wire logic rx_space     = (rx_level < flow_ctrl_pkg::RX_FIFO_DEPTH);

   logic md_rx_enabled_next;
   logic sw_halted_next;
   logic addr_seen_reg;
   logic addr_seen_next;

   // address filter; a non-match disables, later match re-enables
   always_comb begin
      md_rx_enabled_next = md_rx_enabled;
      addr_seen_next     = addr_seen_reg;
      if (!md_mode) begin
         md_rx_enabled_next = 1'b0;
         addr_seen_next     = 1'b0;
      end else if (rx_take && md_addr_byte) begin
         md_rx_enabled_next = addr_match;
         addr_seen_next     = addr_match;
      end
   end

   // pending halt waits for the character in the shifter to end
   logic halt_req_reg;
   logic halt_req_next;

   always_comb begin
      sw_halted_next = sw_halted;
      halt_req_next  = halt_req_reg;
      if (!sw_flow) begin
         sw_halted_next = 1'b0;
         halt_req_next  = 1'b0;
      end else if (rx_take && sw_go_hit) begin
         sw_halted_next = 1'b0;
         halt_req_next  = 1'b0;
      end else if (rx_take && sw_stop_hit) begin
         halt_req_next  = 1'b1;
         sw_halted_next = !tx_busy;
      end else if (halt_req_reg && (tx_char_done || !tx_busy)) begin
         sw_halted_next = 1'b1;
         halt_req_next  = 1'b0;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         md_rx_enabled <= 1'b0;
         addr_seen_reg <= 1'b0;
         sw_halted     <= 1'b0;
         halt_req_reg  <= 1'b0;
      end else begin
         md_rx_enabled <= md_rx_enabled_next;
         addr_seen_reg <= addr_seen_next;
         sw_halted     <= sw_halted_next;
         halt_req_reg  <= halt_req_next;
      end
   end

   // FIFO write strobe, one cycle per stored byte
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_write      <= 1'b0;
         rx_write_data <= 8'h00;
      end else begin
         rx_write      <= rx_take && store_ok;
         rx_write_data <= rx_data[7:0];
      end
   end

   // ==========================================
   // driver enable sequencing
   de_state_t  de_state_reg;
   de_state_t  de_state_next;
   logic [3:0] hold_cnt_reg;
   logic [3:0] hold_cnt_next;

   wire logic de_active = (de_state_reg != DE_IDLE);
   wire logic tx_end    = !tx_pending && !tx_busy;

   always_comb begin
      de_state_next = de_state_reg;
      hold_cnt_next = hold_cnt_reg;
      case (de_state_reg)
         DE_IDLE: begin
            if (rs485_mode && tx_pending) begin
               de_state_next = DE_SEND;
            end
         end
         DE_SEND: begin
            if (tx_end) begin
               if (turnaround_delay == flow_ctrl_pkg::DELAY_ZERO) begin
                  de_state_next = DE_IDLE;
               end else begin
                  de_state_next = DE_HOLD;
                  hold_cnt_next = turnaround_delay;
               end
            end
         end
         DE_HOLD: begin
            if (tx_pending) begin
               de_state_next = DE_SEND;
            end else if (bit_tick) begin
               hold_cnt_next = hold_cnt_reg - 4'h1;
               if (hold_cnt_reg == 4'h1) begin
                  de_state_next = DE_IDLE;
               end
            end
         end
         default: begin
            de_state_next = DE_IDLE;
         end
      endcase
      if (!rs485_mode) begin
         de_state_next = DE_IDLE;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         de_state_reg <= DE_IDLE;
         hold_cnt_reg <= 4'h0;
      end else begin
         de_state_reg <= de_state_next;
         hold_cnt_reg <= hold_cnt_next;
      end
   end

   // ==========================================
   // transmit permission; start only once driver enable is already up
   wire logic cts_ok   = !rts_mode || !cts_sync;
   wire logic dsr_ok   = !dtr_mode || !dsr_sync;
   // next-state terms, so a stop character already blocks the very next start
   wire logic sw_ok    = !sw_flow || (!sw_halted_next && !halt_req_next);
   wire logic md_ok    = (fmode != flow_ctrl_pkg::FLOW_MD_TXADDR) || addr_seen_reg;
   // permit only while driver enable stays up across the edge, else a late start slips out
   wire logic de_ok    = !rs485_mode || ((de_state_reg == DE_SEND) && (de_state_next == DE_SEND));
   wire logic start_ok = cts_ok && dsr_ok && sw_ok && md_ok && de_ok;

   // handshake outputs are active low; high means stop sending to us
   wire logic ready_n  = !rx_space;
   wire logic pin5_nxt = rs485_mode ? (de_active ^ de_invert) : (rts_mode ? ready_n : 1'b1);
   wire logic pin3_nxt = dtr_mode ? ready_n : 1'b1;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_start_ok   <= 1'b0;
         general_pin_5 <= 1'b1;
         general_pin_3 <= 1'b1;
      end else begin
         tx_start_ok   <= start_ok;
         general_pin_5 <= pin5_nxt;
         general_pin_3 <= pin3_nxt;
      end
   end

   // ==========================================
   // checks
   sequence s_stop_seen;
      sw_flow && rx_take && sw_stop_hit && !sw_go_hit;
   endsequence

   property p_rts_full;
      @(posedge ref_clk) disable iff (!rst_n)
      (rts_mode && !rx_space) |=> general_pin_5;
   endproperty
   a_rts_full: assert property (p_rts_full) else $error("rts not dropped when full");

   property p_cts_block;
      @(posedge ref_clk) disable iff (!rst_n)
      (rts_mode && cts_sync) |=> !tx_start_ok;
   endproperty
   a_cts_block: assert property (p_cts_block) else $error("sent while cts off");

   property p_stop_halts;
      @(posedge ref_clk) disable iff (!rst_n)
      s_stop_seen |=> !tx_start_ok;
   endproperty
   a_stop_halts: assert property (p_stop_halts) else $error("stop char did not halt");

   property p_go_resumes;
      @(posedge ref_clk) disable iff (!rst_n)
      (sw_flow && rx_take && sw_go_hit) |=> !sw_halted;
   endproperty
   a_go_resumes: assert property (p_go_resumes) else $error("resume char ignored");

   property p_de_before_tx;
      @(posedge ref_clk) disable iff (!rst_n)
      (rs485_mode && tx_start_ok) |-> (de_state_reg != DE_IDLE);
   endproperty
   a_de_before_tx: assert property (p_de_before_tx) else $error("start without driver enable");

   property p_de_polarity;
      @(posedge ref_clk) disable iff (!rst_n)
      ($past(rst_n) && $past(rs485_mode) && rs485_mode) |-> (general_pin_5 == ($past(de_active) ^ $past(de_invert)));
   endproperty
   a_de_polarity: assert property (p_de_polarity) else $error("driver enable polarity wrong");

   property p_addr_not_stored;
      @(posedge ref_clk) disable iff (!rst_n)
      (md_mode && rx_take && is_addr) |=> !rx_write;
   endproperty
   a_addr_not_stored: assert property (p_addr_not_stored) else $error("address byte stored");

   property p_nomatch_off;
      @(posedge ref_clk) disable iff (!rst_n)
      (md_mode && rx_take && is_addr && !addr_match) |=> !md_rx_enabled;
   endproperty
   a_nomatch_off: assert property (p_nomatch_off) else $error("receiver not disabled");

   property p_mode4_gate;
      @(posedge ref_clk) disable iff (!rst_n)
      (fmode == flow_ctrl_pkg::FLOW_MD_TXADDR && !addr_seen_reg) |=> !tx_start_ok;
   endproperty
   a_mode4_gate: assert property (p_mode4_gate) else $error("mode 4 sent without match");

   property p_half_dup;
      @(posedge ref_clk) disable iff (!rst_n)
      (half_dup && tx_busy) |=> !rx_write;
   endproperty
   a_half_dup: assert property (p_half_dup) else $error("receive during transmit");

   property p_dtr_full;
      @(posedge ref_clk) disable iff (!rst_n)
      (dtr_mode && !rx_space) |=> general_pin_3;
   endproperty
   a_dtr_full: assert property (p_dtr_full) else $error("dtr not dropped when full");

   property p_flow_char_dropped;
      @(posedge ref_clk) disable iff (!rst_n)
      (sw_flow && rx_take && (sw_stop_hit || sw_go_hit)) |=> !rx_write;
   endproperty
   a_flow_char_dropped: assert property (p_flow_char_dropped) else $error("flow char stored");

   property p_md_reenable;
      @(posedge ref_clk) disable iff (!rst_n)
      (md_mode && rx_take && is_addr && addr_match) |=> md_rx_enabled;
   endproperty
   a_md_reenable: assert property (p_md_reenable) else $error("receiver not enabled on match");

   // zero delay: state drops at the next edge, the pin one edge later
   sequence s_send_end;
      rs485_mode && (de_state_reg == DE_SEND) && tx_end && (turnaround_delay == flow_ctrl_pkg::DELAY_ZERO);
   endsequence

   property p_de_release;
      @(posedge ref_clk) disable iff (!rst_n)
      s_send_end |=> (de_state_reg == DE_IDLE) ##1 (general_pin_5 == $past(de_invert));
   endproperty
   a_de_release: assert property (p_de_release) else $error("driver enable held too long");
endmodule : uart_flow_multidrop_control
`default_nettype wire

// file: dv/remote_peer.sv
`default_nettype none
// ==========================================
// remote end of the handshake pair, with a settable response lag
module remote_peer (
   input  wire logic       ref_clk,
   input  wire logic       rst_n,
   input  wire logic [1:0] ready,
   input  wire logic [4:0] lag,
   input  wire logic       general_pin_5,
   output var  logic       general_pin_4,
   output var  logic       general_pin_2,
   output var  logic       blocked
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] hist_cts;
   logic [31:0] hist_dsr;
   // ready history; a long lag models a slow remote
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         hist_cts <= '1;
         hist_dsr <= '1;
      end else begin
         hist_cts <= {hist_cts[30:0], ~ready[0]};
         hist_dsr <= {hist_dsr[30:0], ~ready[1]};
      end
   end
   // pins are active low, so a busy remote holds them high
   assign general_pin_4 = hist_cts[lag];
   assign general_pin_2 = hist_dsr[lag];
   // remote must hold off while our request line is high
   assign blocked       = general_pin_5;
endmodule : remote_peer
`default_nettype wire

// file: dv/tb.sv
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic       ref_clk, rst_n, tx_pending, tx_busy, tx_char_done, bit_tick, tx_start_ok, rx_valid, rx_write;
   logic       general_pin_4, general_pin_2, general_pin_5, general_pin_3, md_rx_enabled, sw_halted, blocked;
   logic [3:0] flow_mode, pin_mode, turnaround_delay;
   logic [7:0] resume_char, stop_char, rx_write_data;
   logic [8:0] rx_data, rx_level;
   logic [1:0] peer_ready;
   logic [4:0] peer_lag;
   logic [7:0] exp_q[$];
   int         error_cnt, checks_done, md_en, ticks;
   int         dly[4] = '{0, 1, 15, 5};
   integer     seed;
   uart_flow_multidrop_control dut (.ref_clk(ref_clk), .rst_n(rst_n), .flow_mode(flow_mode), .pin_mode(pin_mode),
      .resume_char(resume_char), .stop_char(stop_char), .turnaround_delay(turnaround_delay),
      .tx_pending(tx_pending), .tx_busy(tx_busy), .tx_char_done(tx_char_done), .bit_tick(bit_tick),
      .tx_start_ok(tx_start_ok), .rx_valid(rx_valid), .rx_data(rx_data), .rx_level(rx_level), .rx_write(rx_write),
      .rx_write_data(rx_write_data), .general_pin_4(general_pin_4), .general_pin_2(general_pin_2),
      .general_pin_5(general_pin_5), .general_pin_3(general_pin_3), .md_rx_enabled(md_rx_enabled),
      .sw_halted(sw_halted));
   remote_peer peer (.ref_clk(ref_clk), .rst_n(rst_n), .ready(peer_ready), .lag(peer_lag),
      .general_pin_5(general_pin_5), .general_pin_4(general_pin_4), .general_pin_2(general_pin_2), .blocked(blocked));
   // ==========================================
   // clock
   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   // ==========================================
   // shared tasks
   task automatic results();
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : results
   task automatic check(input string name, input logic [8:0] exp, input logic [8:0] got);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask : check
   function automatic logic pick(input int sel);
      case (sel)
         0: return tx_start_ok;
         1: return general_pin_5;
         2: return general_pin_3;
         3: return sw_halted;
         default: return md_rx_enabled;
      endcase
   endfunction : pick
   // bounded wait; a miss is fatal to the run since later steps depend on it
   // returns on a rising edge so the caller's next drive lands on that edge
   task automatic wait_for(input int sel, input logic want, input string name);
      int n;
      n = 0;
      while (pick(sel) !== want && n < 48) begin
         @(negedge ref_clk);
         n++;
      end
      check(name, {8'h00, want}, {8'h00, pick(sel)});
      if (pick(sel) !== want) results();
      @(posedge ref_clk);
   endtask : wait_for
   task automatic do_reset(input logic [3:0] fm, input logic [3:0] pm);
      @(posedge ref_clk);
      rst_n      <= 1'b0;
      flow_mode  <= fm;
      pin_mode   <= pm;
      tx_pending <= 1'b0;
      tx_busy    <= 1'b0;
      rx_level   <= 9'h000;
      @(negedge ref_clk);
      check("reset outputs", 9'h00C, {3'h0, tx_start_ok, rx_write, general_pin_5, general_pin_3, md_rx_enabled,
         sw_halted});
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
      md_en = 0;
   endtask : do_reset
   // one byte per call, so consecutive calls give back-to-back bytes
   task automatic rx_byte(input logic [8:0] d);
      logic hit;
      @(posedge ref_clk);
      rx_valid <= 1'b1;
      rx_data  <= d;
      hit = (d[7:0] == resume_char) || (d[7:0] == stop_char);
      if (flow_mode[3] && tx_busy) begin
         return;
      end
      if (flow_mode[2:0] == flow_ctrl_pkg::FLOW_SW) begin
         if (!hit) exp_q.push_back(d[7:0]);
      end else if (flow_mode[2:0] == flow_ctrl_pkg::FLOW_MD_TXANY || flow_mode[2:0] == flow_ctrl_pkg::FLOW_MD_TXADDR) begin
         if (d[8]) md_en = hit;
         else if (md_en != 0) exp_q.push_back(d[7:0]);
      end else begin
         exp_q.push_back(d[7:0]);
      end
   endtask : rx_byte
   task automatic rx_idle();
      @(posedge ref_clk);
      rx_valid <= 1'b0;
   endtask : rx_idle
   // model of the receive FIFO write stream
   always @(negedge ref_clk) begin
      if (rx_write === 1'b1) begin
         if (exp_q.size() == 0) check("unexpected rx_write", 9'h000, 9'h1FF);
         else check("rx_write_data", {1'b0, exp_q.pop_front()}, {1'b0, rx_write_data});
      end
   end
   // ==========================================
   // scenarios
   initial begin
      {rst_n, tx_pending, tx_busy, tx_char_done, bit_tick, rx_valid} = '0;
      {flow_mode, pin_mode, turnaround_delay, rx_data, rx_level} = '0;
      {error_cnt, checks_done, md_en} = '0;
      resume_char = 8'h11;
      stop_char   = 8'h13;
      peer_ready  = 2'h3;
      peer_lag    = 5'h00;
      seed        = 32'h62233bbd;
      // plain pass-through, random back-to-back bytes
      do_reset(4'h0, 4'h0);
      repeat (8) rx_byte({1'b0, 8'($random(seed))});
      rx_idle();
      // software flow: stop lands mid-character, halt waits for its end
      do_reset({1'b0, flow_ctrl_pkg::FLOW_SW}, 4'h0);
      tx_pending <= 1'b1;
      tx_busy    <= 1'b1;
      wait_for(0, 1'b1, "sw start allowed");
      // top bit set keeps random bytes clear of the two flow characters
      rx_byte({1'b0, 8'($random(seed)) | 8'h80});
      rx_byte({1'b0, stop_char});
      rx_idle();
      wait_for(0, 1'b0, "sw stop blocks start");
      check("halt waits for char end", 9'h000, {8'h00, sw_halted});
      @(posedge ref_clk);
      tx_char_done <= 1'b1;
      tx_busy      <= 1'b0;
      @(posedge ref_clk);
      tx_char_done <= 1'b0;
      wait_for(3, 1'b1, "sw halted");
      rx_byte({1'b0, resume_char});
      rx_byte({1'b0, 8'($random(seed)) | 8'h80});
      rx_idle();
      wait_for(3, 1'b0, "sw resumed");
      wait_for(0, 1'b1, "sw start again");
      // hardware flow on both pin pairs, prompt and slow remote
      for (int i = 0; i < 4; i++) begin
         do_reset({1'b0, flow_ctrl_pkg::FLOW_HW}, i[0] ? 4'h2 : 4'h1);
         peer_lag   <= i[1] ? 5'h13 : 5'h00;
         peer_ready <= i[0] ? 2'h2 : 2'h1; // off pin stays not ready
         tx_pending <= 1'b1;
         wait_for(0, 1'b1, "hw start allowed");
         wait_for(i[0] ? 2 : 1, 1'b0, "ready out asserted");
         rx_level <= flow_ctrl_pkg::RX_FIFO_DEPTH;
         wait_for(i[0] ? 2 : 1, 1'b1, "ready out on full");
         if (!i[0]) check("remote held off", 9'h001, {8'h00, blocked});
         rx_level <= 9'h17F;
         wait_for(i[0] ? 2 : 1, 1'b0, "ready out on space");
         peer_ready <= 2'h0;
         wait_for(0, 1'b0, "hw start paused");
         peer_ready <= i[0] ? 2'h2 : 2'h1;
         wait_for(0, 1'b1, "hw start resumed");
      end
      // driver enable with both modes, both polarities, several delays
      for (int i = 0; i < 4; i++) begin
         do_reset(4'h0, {i[1], i[0] ? flow_ctrl_pkg::PIN_RS485_B : flow_ctrl_pkg::PIN_RS485_A});
         turnaround_delay <= 4'(dly[i]);
         wait_for(1, i[1], "driver idle level");
         tx_pending <= 1'b1;
         wait_for(0, 1'b1, "rs485 start");
         check("driver on at start", {8'h00, ~i[1]}, {8'h00, general_pin_5});
         @(posedge ref_clk);
         tx_busy    <= 1'b1;
         tx_pending <= 1'b0;
         repeat (10) @(posedge ref_clk);
         tx_char_done <= 1'b1;
         tx_busy      <= 1'b0;
         @(posedge ref_clk);
         tx_char_done <= 1'b0;
         ticks = 0;
         // ticks spaced 6 cycles so a release is seen before the next tick
         for (int k = 0; k < 120 && general_pin_5 !== i[1]; k++) begin
            @(posedge ref_clk);
            bit_tick <= (k % 6 == 5);
            if (k % 6 == 5) ticks++;
            @(negedge ref_clk);
         end
         bit_tick <= 1'b0;
         check("driver hold ticks", 9'(dly[i]), 9'(ticks));
         if (general_pin_5 !== i[1]) results();
      end
      // multidrop, transmit only after a match
      do_reset({1'b0, flow_ctrl_pkg::FLOW_MD_TXADDR}, 4'h0);
      tx_pending <= 1'b1;
      wait_for(0, 1'b0, "md4 tx held before match");
      rx_byte(9'h055);
      rx_byte(9'h1AA);
      rx_byte(9'h056);
      rx_byte({1'b1, resume_char});
      rx_idle();
      wait_for(4, 1'b1, "unicast match");
      wait_for(0, 1'b1, "md4 tx after match");
      repeat (2) rx_byte({1'b0, 8'($random(seed))});
      rx_byte({1'b1, stop_char});
      rx_byte(9'h0A5);
      rx_byte(9'h1A5);
      rx_byte(9'h05A);
      rx_idle();
      wait_for(4, 1'b0, "mismatch disables");
      wait_for(0, 1'b0, "md4 tx cleared");
      // multidrop, transmit regardless
      do_reset({1'b0, flow_ctrl_pkg::FLOW_MD_TXANY}, 4'h0);
      tx_pending <= 1'b1;
      wait_for(0, 1'b1, "md3 tx free");
      rx_byte({1'b1, stop_char});
      rx_byte(9'h0C3);
      rx_idle();
      wait_for(4, 1'b1, "multicast match");
      // half duplex blanking while transmitting
      do_reset(4'h8, 4'h0);
      @(posedge ref_clk);
      tx_busy <= 1'b1;
      repeat (3) rx_byte({1'b0, 8'($random(seed))});
      rx_idle();
      tx_busy <= 1'b0;
      repeat (2) rx_byte({1'b0, 8'($random(seed))});
      rx_idle();
      repeat (3) @(negedge ref_clk);
      check("rx writes outstanding", 9'h000, 9'(exp_q.size()));
      results();
   end
endmodule : tb
`default_nettype wire
